// ===== rtl/flash_sections_pkg.sv
// Purpose: shared constants for the flash self-programming section control
// Assumes: word-addressed program memory, 16-bit program counter and Z pointer
// Notes:   register map sits on APB, one aligned 32-bit word per register
`default_nettype none
package flash_sections_pkg;
	localparam int unsigned ADDR_W = 16;
	// apb byte offsets
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
	localparam logic [7:0] OFS_LOCKS       = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h0c;
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h10;
	localparam logic [7:0] OFS_FUSES       = 8'h14;
	// self_program_ctrl_status fields
	localparam int unsigned BIT_START = 0;
	localparam int unsigned BIT_ERASE = 1;
	localparam int unsigned BIT_BUSY  = 6;
	localparam int unsigned BIT_ACTIVE = 7;
	// lock register fields
	localparam int unsigned LOCK_APP_LSB  = 0;
	localparam int unsigned LOCK_BOOT_LSB = 2;
	localparam logic [1:0] LOCK_FREE       = 2'h3;
	localparam logic [1:0] LOCK_NO_WRITE   = 2'h2;
	localparam logic [1:0] LOCK_NO_RW      = 2'h0;
	localparam logic [1:0] LOCK_NO_READ    = 2'h1;
	// interrupt event bits
	localparam int unsigned EV_DONE    = 0;
	localparam int unsigned EV_REFUSED = 1;
	localparam int unsigned EV_W       = 2;
	localparam logic [1:0] FUSE_RESET = 2'h0;
	// page programming time
	localparam int unsigned CLK_NS      = 50;
	localparam int unsigned PROG_TIME_US = 4;
	localparam int unsigned PROG_CYCLES = (PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {ST_IDLE, ST_PROG} prog_state_t;
endpackage
`default_nettype wire

// ===== rtl/flash_self_program_sections.sv
// Purpose: section control for flash self-programming: boot/app split, locks, stall, busy
// Assumes: cpu issues store_program_instruction with the pc and z pointer it holds
// Notes:   single clock, apb register slave, one level interrupt
//
// Behaviour
// - flash splits into application and boot sections at a fuse-selected boundary
// - programming starts only when the store instruction executes in the boot section
// - from the boot section the store may target any address, boot pages too
// - application and boot sections have independent lock-bit pairs
// - flash also has fixed concurrent-read and halting regions, independent of fuses
// - region being programmed is chosen from the z pointer at the store
// - concurrent-read section programming keeps cpu running, reads from halting only
// - halting section programming stalls the cpu with no flash reads
// - boot section always lies wholly inside the halting section
// - busy flag reads one while concurrent section is blocked for reading
// - busy flag stays set after programming until software clears it
// - erase and write act on whole pages; reads are not paged
// - lock pair 11 free, 10 no write, 00 no write or read, 01 no read
// - busy flag sits at bit six of the control and status register
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sections
	import flash_sections_pkg::*;
#(
	parameter int unsigned PAGE_WORDS = 64,
	parameter logic [ADDR_W-1:0] HALT_BASE = 16'h3800,
	parameter logic [ADDR_W-1:0] BOOT_BASE_0 = 16'h3800,
	parameter logic [ADDR_W-1:0] BOOT_BASE_1 = 16'h3c00,
	parameter logic [ADDR_W-1:0] BOOT_BASE_2 = 16'h3e00,
	parameter logic [ADDR_W-1:0] BOOT_BASE_3 = 16'h3f00,
	parameter int unsigned PROG_LEN = PROG_CYCLES
) (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic [1:0]        i_boot_size_fuses,
	input  wire logic              i_store_exec,
	input  wire logic [ADDR_W-1:0] i_pc,
	input  wire logic [ADDR_W-1:0] i_z_ptr,
	input  wire logic              i_lpm_exec,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic                   o_cpu_halt,
	output logic                   o_concurrent_read_block,
	output logic                   o_flash_prog,
	output logic [ADDR_W-1:0]      o_page_base,
	output logic                   o_page_erase,
	output logic                   o_lpm_denied,
	output logic                   o_irq
);
	localparam int unsigned PAGE_BITS = $clog2(PAGE_WORDS);
	localparam int unsigned CNT_W = $clog2(PROG_LEN + 1);

	if (PAGE_WORDS < 2 || (1 << PAGE_BITS) != PAGE_WORDS) begin : g_bad_page
		$error("PAGE_WORDS must be a power of two");
	end
	if (BOOT_BASE_0 < HALT_BASE || BOOT_BASE_1 < HALT_BASE
			|| BOOT_BASE_2 < HALT_BASE || BOOT_BASE_3 < HALT_BASE) begin : g_bad_boot
		$error("boot section must lie inside the halting section");
	end
	if (PROG_LEN < 1) begin : g_bad_len
		$error("PROG_LEN must be at least one");
	end

	// ==========================================================
	// address decoding
	function automatic logic [ADDR_W-1:0] boot_base(input logic [1:0] sz);
		unique case (sz)
			2'h0: boot_base = BOOT_BASE_0;
			2'h1: boot_base = BOOT_BASE_1;
			2'h2: boot_base = BOOT_BASE_2;
			2'h3: boot_base = BOOT_BASE_3;
		endcase
	endfunction

	function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
		in_boot = a >= boot_base(sz);
	endfunction

	function automatic logic in_halt(input logic [ADDR_W-1:0] a);
		in_halt = a >= HALT_BASE;
	endfunction

	// fuses caught once after reset release
	logic [1:0] boot_size_fuses;
	logic       fuse_taken;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			boot_size_fuses <= FUSE_RESET;
			fuse_taken      <= 1'b0;
		end else if (!fuse_taken) begin
			boot_size_fuses <= i_boot_size_fuses;
			fuse_taken      <= 1'b1;
		end
	end

	// ==========================================================
	// registers and programming state
	prog_state_t        state, next_state;
	logic [CNT_W-1:0]   cnt, next_cnt;
	logic               busy, next_busy;
	logic               arm_start, next_arm_start;
	logic               arm_erase, next_arm_erase;
	logic [1:0]         app_lock_pair, next_app_lock_pair;
	logic [1:0]         boot_lock_pair, next_boot_lock_pair;
	logic               tgt_halt, next_tgt_halt;
	logic [ADDR_W-1:0]  page_base, next_page_base;
	logic               page_erase, next_page_erase;
	logic [EV_W-1:0]    ev_status, next_ev_status;
	logic [EV_W-1:0]    ev_enable, next_ev_enable;
	logic [31:0]        prdata, next_prdata;
	logic               pready, next_pready;
	logic               pslverr, next_pslverr;
	logic               lpm_denied, next_lpm_denied;

	logic wr_acc, rd_acc, store_ok, tgt_boot, from_boot, locked;
	logic [EV_W-1:0] ev_set, ev_clr;

	always_comb begin
		wr_acc    = i_psel && i_penable && i_pwrite && !pready;
		rd_acc    = i_psel && i_penable && !i_pwrite && !pready;
		from_boot = in_boot(i_pc, boot_size_fuses);
		tgt_boot  = in_boot(i_z_ptr, boot_size_fuses);
		// write lock when the pair is 10 or 00
		locked    = tgt_boot ? !boot_lock_pair[0] : !app_lock_pair[0];
		store_ok  = i_store_exec && arm_start && from_boot && !locked && state == ST_IDLE;
		ev_set    = '0;
		ev_clr    = '0;

		next_state          = state;
		next_cnt            = cnt;
		next_busy           = busy;
		next_arm_start      = arm_start;
		next_arm_erase      = arm_erase;
		next_app_lock_pair  = app_lock_pair;
		next_boot_lock_pair = boot_lock_pair;
		next_tgt_halt       = tgt_halt;
		next_page_base      = page_base;
		next_page_erase     = page_erase;
		next_prdata         = prdata;
		next_pready         = 1'b0;
		next_pslverr        = 1'b0;

		unique case (state)
			ST_IDLE: begin
				if (store_ok) begin
					next_state      = ST_PROG;
					next_cnt        = CNT_W'(PROG_LEN);
					next_tgt_halt   = in_halt(i_z_ptr);
					next_page_base  = {i_z_ptr[ADDR_W-1:PAGE_BITS], PAGE_BITS'(0)};
					next_page_erase = arm_erase;
					next_arm_start  = 1'b0;
					if (!in_halt(i_z_ptr))
						next_busy = 1'b1;
				end else if (i_store_exec && arm_start) begin
					next_arm_start = 1'b0;
					ev_set[EV_REFUSED] = 1'b1;
				end
			end
			ST_PROG: begin
				if (cnt == CNT_W'(1)) begin
					next_state = ST_IDLE;
					ev_set[EV_DONE] = 1'b1;
				end
				next_cnt = cnt - CNT_W'(1);
			end
			default: next_state = ST_IDLE;
		endcase

		if (wr_acc) begin
			next_pready = 1'b1;
			unique case (i_paddr)
				OFS_CTRL_STATUS: begin
					next_arm_start = i_pwdata[BIT_START];
					next_arm_erase = i_pwdata[BIT_ERASE];
					// write one clears busy, refused while section is blocked
					if (i_pwdata[BIT_BUSY] && !(state == ST_PROG && !tgt_halt) && !store_ok)
						next_busy = 1'b0;
				end
				OFS_LOCKS: begin
					// lock bits only go programmed (toward zero)
					next_app_lock_pair  = app_lock_pair & i_pwdata[LOCK_APP_LSB +: 2];
					next_boot_lock_pair = boot_lock_pair & i_pwdata[LOCK_BOOT_LSB +: 2];
				end
				OFS_IRQ_ENABLE:  ;
				OFS_IRQ_CLEAR:   ev_clr = i_pwdata[EV_W-1:0];
				OFS_IRQ_STATUS, OFS_FUSES: ;
				default: next_pslverr = 1'b1;
			endcase
		end else if (rd_acc) begin
			next_pready = 1'b1;
			next_prdata = '0;
			unique case (i_paddr)
				OFS_CTRL_STATUS: begin
					next_prdata[BIT_START]  = arm_start;
					next_prdata[BIT_ERASE]  = arm_erase;
					next_prdata[BIT_BUSY]   = busy;
					next_prdata[BIT_ACTIVE] = state == ST_PROG;
				end
				OFS_LOCKS: begin
					next_prdata[LOCK_APP_LSB +: 2]  = app_lock_pair;
					next_prdata[LOCK_BOOT_LSB +: 2] = boot_lock_pair;
				end
				OFS_IRQ_STATUS:  next_prdata[EV_W-1:0] = ev_status;
				OFS_IRQ_ENABLE:  next_prdata[EV_W-1:0] = ev_enable;
				OFS_IRQ_CLEAR:   ;
				OFS_FUSES:       next_prdata[1:0] = boot_size_fuses;
				default:         next_pslverr = 1'b1;
			endcase
		end

		next_ev_enable = (wr_acc && i_paddr == OFS_IRQ_ENABLE) ? i_pwdata[EV_W-1:0] : ev_enable;
		next_ev_status = (ev_status & ~ev_clr) | ev_set; // set wins over clear

		// cross-section read locks (pairs 00 and 01 clear bit 1)
		if (from_boot && !in_boot(i_z_ptr, boot_size_fuses))
			next_lpm_denied = i_lpm_exec && !app_lock_pair[1];
		else if (!from_boot && in_boot(i_z_ptr, boot_size_fuses))
			next_lpm_denied = i_lpm_exec && !boot_lock_pair[1];
		else
			next_lpm_denied = 1'b0;
		// no read into the concurrent section while it is blocked
		if (i_lpm_exec && next_busy && !in_halt(i_z_ptr))
			next_lpm_denied = 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state          <= ST_IDLE;
			cnt            <= '0;
			busy           <= 1'b0;
			arm_start      <= 1'b0;
			arm_erase      <= 1'b0;
			app_lock_pair  <= LOCK_FREE;
			boot_lock_pair <= LOCK_FREE;
			tgt_halt       <= 1'b0;
			page_base      <= '0;
			page_erase     <= 1'b0;
			ev_status      <= '0;
			ev_enable      <= '0;
			prdata         <= '0;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			lpm_denied     <= 1'b0;
		end else begin
			state          <= next_state;
			cnt            <= next_cnt;
			busy           <= next_busy;
			arm_start      <= next_arm_start;
			arm_erase      <= next_arm_erase;
			app_lock_pair  <= next_app_lock_pair;
			boot_lock_pair <= next_boot_lock_pair;
			tgt_halt       <= next_tgt_halt;
			page_base      <= next_page_base;
			page_erase     <= next_page_erase;
			ev_status      <= next_ev_status;
			ev_enable      <= next_ev_enable;
			prdata         <= next_prdata;
			pready         <= next_pready;
			pslverr        <= next_pslverr;
			lpm_denied     <= next_lpm_denied;
		end
	end

	// ==========================================================
	// registered outputs
	logic halt_q, block_q, irq_q, prog_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prog_q  <= 1'b0;
			halt_q  <= 1'b0;
			block_q <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			halt_q  <= next_state == ST_PROG && next_tgt_halt;
			block_q <= next_state == ST_PROG && !next_tgt_halt;
			irq_q   <= |(next_ev_status & next_ev_enable);
			prog_q  <= next_state == ST_PROG;
		end
	end

	assign o_prdata                = prdata;
	assign o_pready                = pready;
	assign o_pslverr               = pslverr;
	assign o_cpu_halt              = halt_q;
	assign o_concurrent_read_block = block_q;
	assign o_flash_prog            = prog_q;
	assign o_page_base             = page_base;
	assign o_page_erase            = page_erase;
	assign o_lpm_denied            = lpm_denied;
	assign o_irq                   = irq_q;

	// ==========================================================
	// checks
	chk_app_start_ignored: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_store_exec && !from_boot && state == ST_IDLE |=> state == ST_IDLE)
		else $error("store from application section started programming");
	chk_halt_whole_op: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_PROG && tgt_halt |-> halt_q && !block_q)
		else $error("cpu not halted during halting section programming");
	chk_concurrent_runs: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_PROG && !tgt_halt |-> !halt_q && busy)
		else $error("cpu halted or busy low during concurrent programming");
	chk_busy_sticky: assert property (@(posedge i_clk) disable iff (!i_nrst)
		busy && !(wr_acc && i_paddr == OFS_CTRL_STATUS && i_pwdata[BIT_BUSY]) |=> busy)
		else $error("busy flag dropped without software clear");
	chk_busy_clear_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_PROG && !tgt_halt && cnt > CNT_W'(1) |=> busy)
		else $error("busy flag cleared while section still blocked");
	chk_locked_no_prog: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_store_exec && state == ST_IDLE && locked |=> state == ST_IDLE)
		else $error("locked section was programmed");
	chk_prog_length: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(state == ST_PROG) |-> cnt == CNT_W'(PROG_LEN))
		else $error("page operation length wrong");
	chk_page_aligned: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == ST_PROG |-> page_base[PAGE_BITS-1:0] == '0)
		else $error("page base not aligned");
	chk_boot_in_halt: assert property (@(posedge i_clk) disable iff (!i_nrst)
		in_boot(i_z_ptr, boot_size_fuses) |-> in_halt(i_z_ptr))
		else $error("boot section outside halting section");
	chk_irq_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
		|(ev_status & ev_enable) |-> o_irq)
		else $error("interrupt low with enabled status set");
endmodule // flash_self_program_sections
`default_nettype wire

// ===== testbench/cpu_core_model.sv
// Purpose: behavioural cpu core issuing store and load instructions
// Assumes: one clock, instructions issued right after a rising edge
// Notes:   z pointer is scrambled between instructions so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model #(
	parameter logic [15:0] HALT_BASE = 16'h3800
) (
	input  wire logic        i_clk,
	input  wire logic        i_cpu_halt,
	input  wire logic        i_read_block,
	input  wire logic        i_lpm_denied,
	output logic             o_store_exec,
	output logic             o_lpm_exec,
	output logic [15:0]      o_pc,
	output logic [15:0]      o_z_ptr
);
	initial begin
		o_store_exec = 1'b0;
		o_lpm_exec = 1'b0;
		o_pc = 16'h0000;
		o_z_ptr = 16'h0000;
	end
	// ==========================================
	// instruction issue
	task automatic issue(input logic is_store, input logic [15:0] pc, input logic [15:0] z);
		while (i_cpu_halt === 1'b1) @(posedge i_clk);
		@(posedge i_clk);
		o_store_exec <= is_store;
		o_lpm_exec <= !is_store;
		o_pc <= pc;
		o_z_ptr <= z;
		@(posedge i_clk);
		o_store_exec <= 1'b0;
		o_lpm_exec <= 1'b0;
		o_z_ptr <= ~z;
	endtask
	task automatic store(input logic [15:0] pc, input logic [15:0] z);
		issue(1'b1, pc, z);
	endtask
	// no load is issued into a section that is blocked for reading
	task automatic load(input logic [15:0] pc, input logic [15:0] z, output logic denied);
		denied = 1'b0;
		if (i_read_block !== 1'b1 || z >= HALT_BASE) begin
			issue(1'b0, pc, z);
			repeat (3) begin
				@(posedge i_clk);
				if (i_lpm_denied === 1'b1) denied = 1'b1;
			end
		end
	endtask
endmodule // cpu_core_model
`default_nettype wire

// ===== testbench/tb_flash_self_program_sections.sv
// Purpose: self-checking bench for flash section control
// Assumes: apb master in the bench, cpu model on the far side
// Notes:   expected read values and masks are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_sections;
	import flash_sections_pkg::*;
	localparam logic [15:0] HB = 16'h3800;
	localparam int PL = 40;
	logic i_clk = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [1:0] fuse;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, o_prdata, seed;
	logic o_pready, o_pslverr, o_cpu_halt, o_blk, o_flash_prog, o_page_erase, o_lpm_denied, o_irq;
	logic st_exec, lpm, den;
	logic [15:0] pc, z, o_page_base, bb, pcb, zc;
	logic [32:0] exp_q[$], msk_q[$], e, m;
	int miscompares = 0, check_count = 0;
	flash_self_program_sections #(.PROG_LEN(PL), .HALT_BASE(HB)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_boot_size_fuses(fuse), .i_store_exec(st_exec), .i_pc(pc), .i_z_ptr(z), .i_lpm_exec(lpm),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_cpu_halt(o_cpu_halt), .o_concurrent_read_block(o_blk), .o_flash_prog(o_flash_prog),
		.o_page_base(o_page_base), .o_page_erase(o_page_erase), .o_lpm_denied(o_lpm_denied),
		.o_irq(o_irq));
	cpu_core_model #(.HALT_BASE(HB)) cpu (.i_clk(i_clk), .i_cpu_halt(o_cpu_halt),
		.i_read_block(o_blk), .i_lpm_denied(o_lpm_denied), .o_store_exec(st_exec),
		.o_lpm_exec(lpm), .o_pc(pc), .o_z_ptr(z));
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] want);
		check_count++;
		if (got !== want) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d, input logic [32:0] k);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d[31:0];
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(k);
		end
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (o_pready !== 1'b1) @(posedge i_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always @(posedge i_clk) begin
		if (psel && penable && o_pready === 1'b1 && !pwrite) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk({o_pslverr, o_prdata} & m, e & m);
		end
	end
	// one page operation: arm, store, check the routing, wait for the end
	task automatic prog(input logic er, input logic [15:0] p, input logic [15:0] t, input logic ok);
		int n;
		time t0;
		apb(1, OFS_CTRL_STATUS, {31'h0, 1'b1} | (er << BIT_ERASE), 0);
		cpu.store(p, t);
		@(posedge i_clk);
		#1;
		t0 = $time;
		chk(o_flash_prog, ok);
		if (ok) begin
			chk({o_cpu_halt, o_blk}, {t >= HB, t < HB});
			chk({o_page_erase, o_page_base}, {er, t & 16'hffc0});
			if (t < HB) begin
				apb(0, OFS_CTRL_STATUS, 33'h40, 33'h40);
				apb(1, OFS_CTRL_STATUS, 33'h40, 0);
				apb(0, OFS_CTRL_STATUS, 33'h40, 33'h40);
				cpu.load(p, HB, den);
				chk(den, 0);
			end
			n = 0;
			while (o_flash_prog === 1'b1 && n < 100) begin
				@(posedge i_clk);
				n++;
			end
			#1;
			chk(o_flash_prog, 0);
			chk(33'(($time - t0) / CLK_NS), PL);
			chk({o_cpu_halt, o_blk}, 0);
			if (t < HB) begin
				apb(0, OFS_CTRL_STATUS, 33'h40, 33'h40);
				apb(1, OFS_CTRL_STATUS, 33'h40, 0);
				apb(0, OFS_CTRL_STATUS, 33'h0, 33'h40);
			end
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		seed = 32'h3cb3fd91;
		fuse = 2'(rnd());
		bb = (fuse == 2'h0) ? 16'h3800 : (fuse == 2'h1) ? 16'h3c00 : (fuse == 2'h2) ? 16'h3e00 : 16'h3f00;
		pcb = bb + 16'h0010;
		zc = 16'(rnd() % 32'h3800);
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		apb(0, OFS_FUSES, fuse, 33'h3);
		apb(0, OFS_LOCKS, 33'hf, 33'hf);
		apb(0, 8'h18, 33'h100000000, 33'h100000000);
		apb(1, OFS_IRQ_ENABLE, 33'h1, 0);
		prog(0, pcb, zc, 1);
		repeat (2) @(posedge i_clk);
		#1;
		chk(o_irq, 1);
		apb(1, OFS_IRQ_CLEAR, 33'h1, 0);
		repeat (2) @(posedge i_clk);
		#1;
		chk(o_irq, 0);
		prog(1, pcb, bb + (rnd() & 16'h00ff), 1);
		prog(0, pcb, HB, 1);
		prog(0, 16'h0010, zc, 0);
		apb(0, OFS_IRQ_STATUS, 33'h2, 33'h2);
		apb(1, OFS_IRQ_CLEAR, 33'h3, 0);
		apb(1, OFS_IRQ_ENABLE, 33'h0, 0);
		apb(1, OFS_LOCKS, 33'h6, 0);
		apb(0, OFS_LOCKS, 33'h6, 33'hf);
		prog(0, pcb, zc, 0);
		prog(0, pcb, bb, 1);
		repeat (2) @(posedge i_clk);
		#1;
		chk({o_irq, DUT.o_irq}, 0);
		cpu.load(pcb, zc, den);
		chk(den, 0);
		cpu.load(16'h0010, bb, den);
		chk(den, 1);
		apb(1, OFS_LOCKS, 33'h4, 0);
		cpu.load(pcb, zc, den);
		chk(den, 1);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		stop_test();
	end
endmodule // tb_flash_self_program_sections
`default_nettype wire
